// ### hdl/uirq_regs.v
`timescale 1ns/1ps
`include "uirq_map.vh"

module uirq_regs (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [18:0] raw_event_pulse,
  input wire rxd_level,
  input wire clear_to_send_level,
  input wire set_ready_level,
  input wire txd_level,
  input wire request_to_send_level,
  input wire terminal_ready_level,
  input wire [3:0] tx_state_code,
  input wire [3:0] rx_state_code,
  input wire [7:0] tx_fifo_cnt,
  input wire [2:0] tx_mem_cnt,
  input wire [7:0] rx_fifo_cnt,
  input wire [2:0] rx_mem_cnt,
  output wire irq,
  output wire [19:0] divider_integer,
  output wire [3:0] divider_fraction,
  output wire autobaud_en,
  output wire [7:0] pulse_reject_width,
  output wire rxd_filtered
);

  // ==========================================================
  // Storage
  wire [18:0] raw_q;
  reg [18:0] ena_q;
  reg [19:0] div_int_q;
  reg [3:0] div_frac_q;
  reg ab_en_q;
  reg [7:0] ab_filt_q;
  reg [10:0] full_thr_q;
  reg [7:0] aw_addr_q;
  reg aw_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_full_q;
  reg filt_q;
  reg [7:0] filt_cnt_q;

  wire [18:0] masked;
  wire [10:0] rx_count;
  wire [31:0] wr_merge_word;
  wire [31:0] clr_word;
  wire wr_go;
  wire rd_go;
  wire wr_clear;
  wire rd_status;
  reg [18:0] clr_req;
  reg [18:0] clr_eff;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;

  // ==========================================================
  // Byte-lane merge
  function [31:0] merge_lanes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
      merge_lanes = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_lanes[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // Write channel
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;

  always @(posedge clk_sys) begin
    if (srst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UIRQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    case (aw_addr_q)
      `UIRQ_OFS_MASKED_STATUS: wr_hit = 1'b1;
      `UIRQ_OFS_ENABLE: wr_hit = 1'b1;
      `UIRQ_OFS_CLEAR: wr_hit = 1'b1;
      `UIRQ_OFS_BAUD_DIVIDER: wr_hit = 1'b1;
      `UIRQ_OFS_AUTO_BAUD: wr_hit = 1'b1;
      `UIRQ_OFS_LINE_STATUS: wr_hit = 1'b1;
      `UIRQ_OFS_FIFO_MEM_COUNT: wr_hit = 1'b1;
      `UIRQ_OFS_RX_FULL_THRESHOLD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Control registers
  always @(posedge clk_sys) begin
    if (srst) begin
      ena_q <= 19'h00000;
      div_int_q <= `UIRQ_RST_DIV_INT;
      div_frac_q <= `UIRQ_RST_DIV_FRAC;
      ab_en_q <= `UIRQ_RST_AB_EN;
      ab_filt_q <= `UIRQ_RST_AB_FILT;
      full_thr_q <= `UIRQ_RST_FULL_THR;
    end else if (wr_go) begin
      case (aw_addr_q)
        `UIRQ_OFS_ENABLE: begin
          ena_q <= wr_merge_word[18:0];
        end
        `UIRQ_OFS_BAUD_DIVIDER: begin
          div_int_q <= wr_merge_word[`UIRQ_DIV_INT_LSB +: `UIRQ_DIV_INT_W];
          div_frac_q <= wr_merge_word[`UIRQ_DIV_FRAC_LSB +: `UIRQ_DIV_FRAC_W];
        end
        `UIRQ_OFS_AUTO_BAUD: begin
          ab_en_q <= wr_merge_word[`UIRQ_AB_EN_BIT];
          ab_filt_q <= wr_merge_word[`UIRQ_AB_FILT_LSB +: `UIRQ_AB_FILT_W];
        end
        `UIRQ_OFS_RX_FULL_THRESHOLD: begin
          full_thr_q <= wr_merge_word[10:0];
        end
        default: begin
          ena_q <= ena_q;
        end
      endcase
    end
  end

  reg [31:0] old_word;
  always @* begin
    old_word = 32'h0000_0000;
    case (aw_addr_q)
      `UIRQ_OFS_ENABLE: old_word = {13'h0000, ena_q};
      `UIRQ_OFS_BAUD_DIVIDER: old_word = {8'h00, div_frac_q, div_int_q};
      `UIRQ_OFS_AUTO_BAUD: old_word = {16'h0000, ab_filt_q, 7'h00, ab_en_q};
      `UIRQ_OFS_RX_FULL_THRESHOLD: old_word = {21'h000000, full_thr_q};
      default: old_word = 32'h0000_0000;
    endcase
  end

  assign wr_merge_word = merge_lanes(old_word, w_data_q, w_strb_q);

  // ==========================================================
  // Raw events, clears and interrupt
  assign rx_count = {rx_mem_cnt, rx_fifo_cnt};
  assign wr_clear = wr_go & (aw_addr_q == `UIRQ_OFS_CLEAR);
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign rd_status = rd_go & (s_axi_araddr == `UIRQ_OFS_MASKED_STATUS);
  assign clr_word = merge_lanes(32'h0000_0000, w_data_q, w_strb_q);

  always @* begin
    clr_req = 19'h00000;
    if (wr_clear) begin
      clr_req = clr_word[18:0];
    end
    if (rd_status) begin
      clr_req = clr_req | masked;
    end
    clr_eff = clr_req;
    if (rx_count != 11'h000) begin
      clr_eff[`UIRQ_SRC_RX_TIMEOUT] = 1'b0;
    end
    if (!(rx_count < full_thr_q)) begin
      clr_eff[`UIRQ_SRC_RX_FULL] = 1'b0;
    end
  end

  // One sticky flag per interrupt source
  genvar g;
  generate
    for (g = 0; g < `UIRQ_NUM_SRC; g = g + 1) begin : g_src
      uirq_sticky #(
        .RST_VAL(1'b0)
      ) i_sticky (
        .clk_sys(clk_sys),
        .srst(srst),
        .set_pulse(raw_event_pulse[g]),
        .clr_pulse(clr_eff[g]),
        .flag_q(raw_q[g])
      );
    end
  endgenerate

  assign masked = raw_q & ena_q;
  assign irq = |masked;

  // ==========================================================
  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `UIRQ_OFS_MASKED_STATUS: rd_word = {13'h0000, masked};
      `UIRQ_OFS_ENABLE: rd_word = {13'h0000, ena_q};
      `UIRQ_OFS_CLEAR: rd_word = 32'h0000_0000;
      `UIRQ_OFS_BAUD_DIVIDER: rd_word = {8'h00, div_frac_q, div_int_q};
      `UIRQ_OFS_AUTO_BAUD: rd_word = {16'h0000, ab_filt_q, 7'h00, ab_en_q};
      `UIRQ_OFS_LINE_STATUS: begin
        rd_word[`UIRQ_ST_TXD_BIT] = txd_level;
        rd_word[`UIRQ_ST_RTS_BIT] = request_to_send_level;
        rd_word[`UIRQ_ST_DTR_BIT] = terminal_ready_level;
        rd_word[`UIRQ_ST_TX_STATE_LSB +: 4] = tx_state_code;
        rd_word[`UIRQ_ST_TX_CNT_LSB +: 8] = tx_fifo_cnt;
        rd_word[`UIRQ_ST_RXD_BIT] = rxd_level;
        rd_word[`UIRQ_ST_CTS_BIT] = clear_to_send_level;
        rd_word[`UIRQ_ST_DSR_BIT] = set_ready_level;
        rd_word[`UIRQ_ST_RX_STATE_LSB +: 4] = rx_state_code;
        rd_word[`UIRQ_ST_RX_CNT_LSB +: 8] = rx_fifo_cnt;
      end
      `UIRQ_OFS_FIFO_MEM_COUNT: begin
        rd_word[`UIRQ_MEM_RX_LSB +: 3] = rx_mem_cnt;
        rd_word[`UIRQ_MEM_TX_LSB +: 3] = tx_mem_cnt;
      end
      `UIRQ_OFS_RX_FULL_THRESHOLD: rd_word = {21'h000000, full_thr_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UIRQ_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Autobaud pulse filter
  always @(posedge clk_sys) begin
    if (srst) begin
      filt_q <= 1'b1;
      filt_cnt_q <= 8'h00;
    end else if (!ab_en_q || (rxd_level == filt_q)) begin
      filt_q <= rxd_level;
      filt_cnt_q <= 8'h00;
    end else if ((filt_cnt_q + 8'h01) >= ab_filt_q) begin
      filt_q <= rxd_level;
      filt_cnt_q <= 8'h00;
    end else begin
      filt_cnt_q <= filt_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Outputs
  assign divider_integer = div_int_q;
  assign divider_fraction = div_frac_q;
  assign autobaud_en = ab_en_q;
  assign pulse_reject_width = ab_filt_q;
  assign rxd_filtered = filt_q;

endmodule // uirq_regs

// ==========================================================
// Sticky event flag
module uirq_sticky #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_sys,
  input wire srst,
  input wire set_pulse,
  input wire clr_pulse,
  output reg flag_q
);

  // Set wins over a clear in the same cycle
  always @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= RST_VAL;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (clr_pulse) begin
      flag_q <= 1'b0;
    end
  end

endmodule // uirq_sticky

// ### pkg/uirq_map.vh
`ifndef UIRQ_MAP_VH
`define UIRQ_MAP_VH

// ==========================================================
// Register offsets
`define UIRQ_OFS_MASKED_STATUS 8'h08
`define UIRQ_OFS_ENABLE 8'h0c
`define UIRQ_OFS_CLEAR 8'h10
`define UIRQ_OFS_BAUD_DIVIDER 8'h14
`define UIRQ_OFS_AUTO_BAUD 8'h18
`define UIRQ_OFS_LINE_STATUS 8'h1c
`define UIRQ_OFS_FIFO_MEM_COUNT 8'h80
`define UIRQ_OFS_RX_FULL_THRESHOLD 8'h84

// ==========================================================
// Interrupt source bits
`define UIRQ_NUM_SRC 19
`define UIRQ_SRC_RX_FULL 0
`define UIRQ_SRC_TX_EMPTY 1
`define UIRQ_SRC_PARITY_ERR 2
`define UIRQ_SRC_FRAMING_ERR 3
`define UIRQ_SRC_RX_OVERFLOW 4
`define UIRQ_SRC_SET_READY_CHG 5
`define UIRQ_SRC_CLEAR_SEND_CHG 6
`define UIRQ_SRC_BREAK_SEEN 7
`define UIRQ_SRC_RX_TIMEOUT 8
`define UIRQ_SRC_FLOW_RESUME 9
`define UIRQ_SRC_FLOW_STOP 10
`define UIRQ_SRC_GLITCH 11
`define UIRQ_SRC_BREAK_DONE 12
`define UIRQ_SRC_BREAK_IDLE_DONE 13
`define UIRQ_SRC_TX_DONE 14
`define UIRQ_SRC_BUS_PARITY_ERR 15
`define UIRQ_SRC_BUS_FRAMING_ERR 16
`define UIRQ_SRC_BUS_CLASH 17
`define UIRQ_SRC_COMMAND_CHAR 18

// ==========================================================
// Field layouts
`define UIRQ_DIV_INT_LSB 0
`define UIRQ_DIV_INT_W 20
`define UIRQ_DIV_FRAC_LSB 20
`define UIRQ_DIV_FRAC_W 4
`define UIRQ_AB_EN_BIT 0
`define UIRQ_AB_FILT_LSB 8
`define UIRQ_AB_FILT_W 8
`define UIRQ_ST_TXD_BIT 31
`define UIRQ_ST_RTS_BIT 30
`define UIRQ_ST_DTR_BIT 29
`define UIRQ_ST_TX_STATE_LSB 24
`define UIRQ_ST_TX_CNT_LSB 16
`define UIRQ_ST_RXD_BIT 15
`define UIRQ_ST_CTS_BIT 14
`define UIRQ_ST_DSR_BIT 13
`define UIRQ_ST_RX_STATE_LSB 8
`define UIRQ_ST_RX_CNT_LSB 0
`define UIRQ_MEM_RX_LSB 0
`define UIRQ_MEM_TX_LSB 4
`define UIRQ_CNT_W 11

// ==========================================================
// Reset values
`define UIRQ_RST_DIV_INT 20'h00100
`define UIRQ_RST_DIV_FRAC 4'h0
`define UIRQ_RST_AB_FILT 8'h08
`define UIRQ_RST_AB_EN 1'b0
`define UIRQ_RST_FULL_THR 11'h080

// ==========================================================
// Bus responses
`define UIRQ_RESP_OKAY 2'b00
`define UIRQ_RESP_SLVERR 2'b10

`endif

// ### verif/uirq_regs_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Checker on the register block ports
module uirq_regs_chk (
  input logic clk_sys,
  input logic srst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic irq,
  input logic [19:0] divider_integer,
  input logic [3:0] divider_fraction,
  input logic autobaud_en,
  input logic [7:0] pulse_reject_width,
  input logic rxd_level,
  input logic rxd_filtered
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_reset_vals: assert property ($fell(srst) |-> !irq && divider_integer == 20'h00100 && divider_fraction == 4'h0)
    else $error("bad divider or irq after reset");
  a_ab_reset: assert property ($fell(srst) |-> !autobaud_en && pulse_reject_width == 8'h08)
    else $error("bad autobaud after reset");
  a_filter_off: assert property (!autobaud_en ##1 !autobaud_en |-> rxd_filtered == $past(rxd_level))
    else $error("unfiltered receive level wrong");
  a_glitch_ignore: assert property ($past(autobaud_en) && $past(autobaud_en, 2) && $past(pulse_reject_width) > 8'h01 && $changed(rxd_filtered) |-> rxd_filtered == $past(rxd_level) && rxd_filtered == $past(rxd_level, 2))
    else $error("short pulse passed filter");
  c_irq: cover property (irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_glitch: cover property (autobaud_en && $fell(rxd_filtered));
endmodule // uirq_regs_chk

bind uirq_regs uirq_regs_chk i_chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irq(irq),
  .divider_integer(divider_integer),
  .divider_fraction(divider_fraction),
  .autobaud_en(autobaud_en),
  .pulse_reject_width(pulse_reject_width),
  .rxd_level(rxd_level),
  .rxd_filtered(rxd_filtered)
);

// ### verif/uirq_regs_tb.sv
`timescale 1ns/1ps
module uirq_regs_tb;
  logic clk_sys = 0, srst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, seed = 32'h42, v;
  logic [3:0] s_axi_wstrb = 4'hf, tx_state_code = 0, rx_state_code = 0;
  logic [18:0] raw_event_pulse = 0;
  logic rxd_level = 1, clear_to_send_level = 0, set_ready_level = 0, txd_level = 0;
  logic request_to_send_level = 0, terminal_ready_level = 0;
  logic [7:0] tx_fifo_cnt = 0, rx_fifo_cnt = 0;
  logic [2:0] tx_mem_cnt = 0, rx_mem_cnt = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire irq, autobaud_en, rxd_filtered;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [19:0] divider_integer;
  wire [3:0] divider_fraction;
  wire [7:0] pulse_reject_width;
  int miscompares = 0, comparisons = 0, cyc = 0, i;
  logic [1:0] wq[$];
  logic [33:0] rq[$];

  uirq_regs i_dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .raw_event_pulse(raw_event_pulse),
    .rxd_level(rxd_level),
    .clear_to_send_level(clear_to_send_level),
    .set_ready_level(set_ready_level),
    .txd_level(txd_level),
    .request_to_send_level(request_to_send_level),
    .terminal_ready_level(terminal_ready_level),
    .tx_state_code(tx_state_code),
    .rx_state_code(rx_state_code),
    .tx_fifo_cnt(tx_fifo_cnt),
    .tx_mem_cnt(tx_mem_cnt),
    .rx_fifo_cnt(rx_fifo_cnt),
    .rx_mem_cnt(rx_mem_cnt),
    .irq(irq),
    .divider_integer(divider_integer),
    .divider_fraction(divider_fraction),
    .autobaud_en(autobaud_en),
    .pulse_reject_width(pulse_reject_width),
    .rxd_filtered(rxd_filtered)
  );

  initial forever #25 clk_sys = ~clk_sys;

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ap, dp;
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    ap = 1;
    dp = 1;
    while (ap || dp) begin
      @(posedge clk_sys);
      if (ap && s_axi_awready) ap = 0;
      if (dp && s_axi_wready) dp = 0;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= dp;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge clk_sys);
  endtask

  task pulse(input int n);
    raw_event_pulse <= 19'h1 << n;
    @(posedge clk_sys);
    raw_event_pulse <= 0;
    @(posedge clk_sys);
  endtask

  task irqchk(input logic e);
    @(negedge clk_sys);
    chk(irq, e);
    @(posedge clk_sys);
  endtask

  // ==========================================
  // Response monitor and timeout
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end else begin
      if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, wq.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
  end

  // ==========================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    rd(8'h0c, 0);
    rd(8'h08, 0);
    rd(8'h14, 34'h100);
    rd(8'h18, 34'h800);
    rd(8'h10, 0);
    rd(8'h40, {2'b10, 32'h0});
    wr(8'h40, 32'h1, 2'b10);
    v = rnd();
    wr(8'h0c, v, 0);
    rd(8'h0c, v & 32'h7ffff);
    wr(8'h14, v, 0);
    rd(8'h14, v & 32'hffffff);
    chk({divider_fraction, divider_integer}, v[23:0]);
    s_axi_wstrb <= 4'h2;
    wr(8'h14, 0, 0);
    s_axi_wstrb <= 4'hf;
    rd(8'h14, v & 32'hff00ff);
    wr(8'h18, v, 0);
    rd(8'h18, v & 32'hff01);
    chk({pulse_reject_width, autobaud_en}, {v[15:8], v[0]});
    wr(8'h18, 0, 0);
    wr(8'h0c, 0, 0);
    pulse(5);
    irqchk(0);
    rd(8'h08, 0);
    wr(8'h0c, 32'h7ffff, 0);
    irqchk(1);
    rd(8'h08, 34'h20);
    irqchk(0);
    for (i = 0; i < 19; i++) begin
      pulse(i);
      irqchk(1);
      wr(8'h10, 32'h1 << i, 0);
      irqchk(0);
      pulse(i);
      rd(8'h08, 34'h1 << i);
      rd(8'h08, 0);
    end
    rx_fifo_cnt <= 8'h01;
    pulse(8);
    wr(8'h10, 32'h100, 0);
    rx_fifo_cnt <= 8'h00;
    rx_mem_cnt <= 3'h1;
    wr(8'h10, 32'h100, 0);
    rd(8'h08, 34'h100);
    rx_mem_cnt <= 3'h0;
    wr(8'h10, 32'h100, 0);
    rd(8'h08, 0);
    rx_fifo_cnt <= 8'h80;
    pulse(0);
    wr(8'h10, 32'h1, 0);
    rd(8'h08, 34'h1);
    rx_fifo_cnt <= 8'h7f;
    wr(8'h10, 32'h1, 0);
    rd(8'h08, 0);
    wr(8'h1c, 32'hffffffff, 0);
    for (i = 0; i < 15; i++) begin
      v = rnd();
      {txd_level, request_to_send_level, terminal_ready_level} <= v[31:29];
      {rxd_level, clear_to_send_level, set_ready_level} <= v[15:13];
      tx_fifo_cnt <= v[23:16];
      rx_fifo_cnt <= v[7:0];
      tx_mem_cnt <= v[26:24];
      rx_mem_cnt <= v[10:8];
      tx_state_code <= i[3:0];
      rx_state_code <= 4'(i % 14);
      @(posedge clk_sys);
      rd(8'h1c, {v[31:29], 1'b0, i[3:0], v[23:13], 1'b0, 4'(i % 14), v[7:0]});
      rd(8'h80, 34'({v[26:24], 1'b0, v[10:8]}));
    end
    rxd_level <= 1;
    wr(8'h18, 32'h0401, 0);
    repeat (6) @(posedge clk_sys);
    rxd_level <= 0;
    repeat (2) @(posedge clk_sys);
    rxd_level <= 1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(rxd_filtered, 1);
    @(posedge clk_sys);
    rxd_level <= 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(rxd_filtered, 1);
    @(negedge clk_sys);
    chk(rxd_filtered, 0);
    print_verdict();
  end
endmodule // uirq_regs_tb
